// ### include/ocsr_params.svh
// Constants for the output connector signal router
`ifndef OCSR_PARAMS_SVH
`define OCSR_PARAMS_SVH

`define OCSR_OFS_SEL_MK1   4'h0
`define OCSR_OFS_SEL_MK2   4'h1
`define OCSR_OFS_SEL_MK3   4'h2
`define OCSR_OFS_SEL_GEN1_GATE_FOLLOW_SRC  4'h3
`define OCSR_OFS_SEL_PSYN  4'h4
`define OCSR_OFS_STATUS    4'h5

`define OCSR_SEL_LSB       0
`define OCSR_SEL_MSB       4
`define OCSR_STAT_NOPT_BIT 0
`define OCSR_STAT_GEN2_BIT 1
`define OCSR_STAT_REJ_BIT  2

`define OCSR_RST_MK1       5'h00
`define OCSR_RST_MK1_NOPT  5'h0F
`define OCSR_RST_MK2       5'h01
`define OCSR_RST_MK3       5'h02
`define OCSR_RST_GEN1_GATE_FOLLOW_SRC      5'h07
`define OCSR_RST_PSYN      5'h06

`define OCSR_SYNC_STAGES   2

`endif

// ### include/ocsr_pkg.sv
// Types for the output connector signal router
package ocsr_pkg;

    typedef enum logic [4:0] {
        OCSR_SRC_G1M1A  = 5'h00,
        OCSR_SRC_G1M2A  = 5'h01,
        OCSR_SRC_G1M3A  = 5'h02,
        OCSR_SRC_G1M1B  = 5'h03,
        OCSR_SRC_G1M2B  = 5'h04,
        OCSR_SRC_G1M3B  = 5'h05,
        OCSR_SRC_G1PSY  = 5'h06,
        OCSR_SRC_G1PVID = 5'h07,
        OCSR_SRC_G1SET  = 5'h08,
        OCSR_SRC_SYNC   = 5'h09,
        OCSR_SRC_PT1    = 5'h0A,
        OCSR_SRC_PT2    = 5'h0B,
        OCSR_SRC_PT3    = 5'h0C,
        OCSR_SRC_PS1    = 5'h0D,
        OCSR_SRC_POINT  = 5'h0F,
        OCSR_SRC_G2M1A  = 5'h10,
        OCSR_SRC_G2M2A  = 5'h11,
        OCSR_SRC_G2M3A  = 5'h12,
        OCSR_SRC_G2M1B  = 5'h13,
        OCSR_SRC_G2M2B  = 5'h14,
        OCSR_SRC_G2M3B  = 5'h15,
        OCSR_SRC_G2PSY  = 5'h16,
        OCSR_SRC_G2PVID = 5'h17,
        OCSR_SRC_G2SET  = 5'h18
    } ocsr_src_t;

endpackage

// ### include/ocsr_src_if.sv
// Bundle of synchronised source levels between router modules
`timescale 1ns/1ps
`default_nettype none

interface ocsr_src_if;
    logic [31:0] src_vec;
    modport producer (output src_vec);
    modport consumer (input  src_vec);
endinterface

`default_nettype wire

// ### logic/ocsr_retime.sv
// Falling-edge retiming flop for the trigger outputs
`timescale 1ns/1ps
`default_nettype none

module ocsr_retime #(
    parameter int WIDTH = 4
) (
    input  wire logic             i_clk_bbref,
    input  wire logic             i_rst,
    input  wire logic [WIDTH-1:0] i_trig,
    output logic      [WIDTH-1:0] o_trig
);
    // Changes only on the falling edge of the reference clock
    always_ff @(negedge i_clk_bbref)
    begin
        if (i_rst)
            o_trig <= '0;
        else
            o_trig <= i_trig;
    end
endmodule

`default_nettype wire

// ### logic/ocsr_router.sv
// Output connector signal router top
`timescale 1ns/1ps
`default_nettype none
`include "ocsr_params.svh"

module ocsr_router (
    input  wire logic        i_clk_sys,
    input  wire logic        i_rst,
    input  wire logic        i_clk_bbref,
    input  wire logic        i_opt_pattern,
    input  wire logic        i_opt_gen2,
    input  wire logic [3:0]  i_addr,
    input  wire logic [31:0] i_wdata,
    input  wire logic        i_wr,
    input  wire logic        i_rd,
    output logic      [31:0] o_rdata,
    input  wire logic        i_frame_trig,
    input  wire logic [2:0]  i_pattern_trig,
    input  wire logic        i_pattern_stat1_src,
    input  wire logic        i_point_switch,
    input  wire logic [5:0]  i_gen1_marker,
    input  wire logic [5:0]  i_gen2_marker,
    input  wire logic [1:0]  i_cycle_start,
    input  wire logic [1:0]  i_gate_follow,
    input  wire logic [1:0]  i_settling,
    output logic             o_sync_trig,
    output logic [2:0]       o_pattern_trig,
    output logic             o_marker1,
    output logic             o_marker2,
    output logic             o_marker3,
    output logic             o_pulse_video,
    output logic             o_pulse_sync
);
    import ocsr_pkg::*;

    ocsr_src_if src_bus ();

    // Options are straps, caught once after reset
    logic opt_meta_reg;
    logic opt_pat_reg;
    logic g2_meta_reg;
    logic opt_g2_reg;
    logic strap_arm_reg;
    logic strap_done_reg;
    logic strap_seen_reg;
    logic [3:0] retimed;
    logic [31:0] raw_vec;
    logic [31:0] src_vec;

    // Trigger and pattern triggers on the falling edge
    ocsr_retime #(
        .WIDTH (4)
    ) u_retime (
        .i_clk_bbref (i_clk_bbref),
        .i_rst       (i_rst),
        .i_trig      ({i_pattern_trig, i_frame_trig}),
        .o_trig      (retimed)
    );

    assign o_sync_trig    = retimed[0];
    assign o_pattern_trig = retimed[3:1];

    // Raw source vector laid out by selector code
    assign raw_vec[5:0]   = i_gen1_marker;
    assign raw_vec[6]     = i_cycle_start[0];
    assign raw_vec[7]     = i_gate_follow[0];
    assign raw_vec[8]     = ~i_settling[0];
    assign raw_vec[9]     = retimed[0];
    assign raw_vec[12:10] = retimed[3:1];
    assign raw_vec[13]    = i_pattern_stat1_src;
    assign raw_vec[14]    = 1'b0;
    assign raw_vec[15]    = i_point_switch;
    assign raw_vec[21:16] = i_gen2_marker;
    assign raw_vec[22]    = i_cycle_start[1];
    assign raw_vec[23]    = i_gate_follow[1];
    assign raw_vec[24]    = ~i_settling[1];
    assign raw_vec[31:25] = 7'h00;

    ocsr_src_sync u_sync (
        .i_clk_sys (i_clk_sys),
        .i_rst     (i_rst),
        .i_raw     (raw_vec),
        .src       (src_bus.producer)
    );
    assign src_vec = src_bus.src_vec;

    always_ff @(posedge i_clk_sys)
    begin
        if (i_rst)
        begin
            opt_meta_reg   <= 1'b0;
            opt_pat_reg    <= 1'b0;
            g2_meta_reg    <= 1'b0;
            opt_g2_reg     <= 1'b0;
            strap_arm_reg  <= 1'b0;
            strap_done_reg <= 1'b0;
            strap_seen_reg <= 1'b0;
        end
        else
        begin
            opt_meta_reg   <= i_opt_pattern;
            g2_meta_reg    <= i_opt_gen2;
            strap_arm_reg  <= 1'b1;
            strap_done_reg <= strap_arm_reg;
            strap_seen_reg <= strap_done_reg;
            // Catch only once the first stage holds a real pin level
            if (strap_arm_reg && !strap_done_reg)
            begin
                opt_pat_reg <= opt_meta_reg;
                opt_g2_reg  <= g2_meta_reg;
            end
        end
    end

    // Defaults load once, on the third edge after release
    logic strap_load;
    assign strap_load = strap_done_reg && !strap_seen_reg;

    // Legal code check
    function automatic logic code_ok(input logic [4:0] c,
                                     input logic pat,
                                     input logic g2);
        logic known;
        logic needs_pat;
        logic needs_g2;
        known = (c <= 5'h18) && (c != 5'h0E);
        needs_pat = (c <= 5'h05) || ((c >= 5'h09) && (c <= 5'h0D))
                  || ((c >= 5'h10) && (c <= 5'h15));
        needs_g2 = (c >= 5'h10);
        code_ok = known && (pat || !needs_pat) && (g2 || !needs_g2);
    endfunction

    logic [4:0] def_mk1;
    assign def_mk1 = opt_pat_reg ? `OCSR_RST_MK1
                                 : `OCSR_RST_MK1_NOPT;

    // Selector registers, one per marker and pulse output
    logic [4:0] sel_reg  [5];
    logic [4:0] sel_def  [5];
    logic       sel_we   [5];
    logic       rej_reg;
    logic       wr_sel;
    logic       wr_ok;

    assign sel_def[0] = def_mk1;
    assign sel_def[1] = `OCSR_RST_MK2;
    assign sel_def[2] = `OCSR_RST_MK3;
    assign sel_def[3] = `OCSR_RST_GEN1_GATE_FOLLOW_SRC;
    assign sel_def[4] = `OCSR_RST_PSYN;

    assign wr_sel = i_wr && (i_addr <= `OCSR_OFS_SEL_PSYN);
    // Refused codes leave the selector as it was
    assign wr_ok  = code_ok(i_wdata[4:0], opt_pat_reg, opt_g2_reg)
                  && (i_wdata[31:5] == 27'h0)
                  && (opt_pat_reg
                      || ((i_addr != `OCSR_OFS_SEL_MK2)
                          && (i_addr != `OCSR_OFS_SEL_MK3)));

    genvar gi;
    generate
        for (gi = 0; gi < 5; gi++)
        begin : g_sel
            assign sel_we[gi] = wr_sel && wr_ok && (i_addr == 4'(gi));
            always_ff @(posedge i_clk_sys)
            begin
                if (i_rst)
                    sel_reg[gi] <= 5'h00;
                else if (strap_load)
                    sel_reg[gi] <= sel_def[gi];
                else if (sel_we[gi])
                    sel_reg[gi] <= i_wdata[4:0];
            end
        end
    endgenerate

    always_ff @(posedge i_clk_sys)
    begin
        if (i_rst)
            rej_reg <= 1'b0;
        else if (wr_sel)
            rej_reg <= !wr_ok;
    end

    // Output muxes, registered data
    always_ff @(posedge i_clk_sys)
    begin
        if (i_rst)
        begin
            o_marker1     <= 1'b0;
            o_marker2     <= 1'b0;
            o_marker3     <= 1'b0;
            o_pulse_video <= 1'b0;
            o_pulse_sync  <= 1'b0;
        end
        else
        begin
            o_marker1     <= src_vec[sel_reg[0]];
            o_marker2     <= src_vec[sel_reg[1]];
            o_marker3     <= src_vec[sel_reg[2]];
            o_pulse_video <= src_vec[sel_reg[3]];
            o_pulse_sync  <= src_vec[sel_reg[4]];
        end
    end

    // Register read port
    logic [31:0] rd_mux;
    assign rd_mux =
        (i_addr <= `OCSR_OFS_SEL_PSYN)
            ? {27'h0, sel_reg[i_addr[2:0]]}
        : (i_addr == `OCSR_OFS_STATUS)
            ? {29'h0, rej_reg, opt_g2_reg, !opt_pat_reg}
        : 32'h0000_0000;

    always_ff @(posedge i_clk_sys)
    begin
        if (i_rst)
            o_rdata <= 32'h0000_0000;
        else if (i_rd)
            o_rdata <= rd_mux;
        else
            o_rdata <= 32'h0000_0000;
    end

    // Steps of a selector write, shared by the checks below
    sequence seq_mk1_write;
        sel_we[0] && !strap_load;
    endsequence
    sequence seq_mk1_holds;
        sel_reg[0] == $past(i_wdata[4:0]);
    endsequence
    sequence seq_refused_write;
        wr_sel && !wr_ok;
    endsequence

    AST_REFUSE_NOPT: assert property (
        @(posedge i_clk_sys) disable iff (i_rst)
        (strap_done_reg && !opt_pat_reg && i_wr && (i_addr == 4'h0)
         && (i_wdata == 32'h0))
        |=> (sel_reg[0] == $past(sel_reg[0])))
        else $error("marker code accepted without option");
    AST_REJ_FLAG: assert property (
        @(posedge i_clk_sys) disable iff (i_rst)
        seq_refused_write |=> rej_reg)
        else $error("refused write not flagged");
    AST_LOCK_MK2: assert property (
        @(posedge i_clk_sys) disable iff (i_rst)
        (!opt_pat_reg && strap_done_reg && !strap_load)
        |=> $stable(sel_reg[1]))
        else $error("marker 2 selector changed without option");
    AST_LOCK_MK3: assert property (
        @(posedge i_clk_sys) disable iff (i_rst)
        (!opt_pat_reg && strap_done_reg && !strap_load)
        |=> $stable(sel_reg[2]))
        else $error("marker 3 selector changed without option");
    AST_G2_REF: assert property (
        @(posedge i_clk_sys) disable iff (i_rst)
        (strap_done_reg && !opt_g2_reg && i_wr && (i_addr == 4'h4)
         && (i_wdata == 32'h16))
        |=> $stable(sel_reg[4]))
        else $error("generator two code accepted");
    AST_NO_G2_CODE: assert property (
        @(posedge i_clk_sys) disable iff (i_rst)
        (strap_done_reg && !opt_g2_reg)
        |-> ((sel_reg[3] < 5'h16) && (sel_reg[4] < 5'h16)))
        else $error("generator two pulse source selected");
    AST_DEF_MK1: assert property (
        @(posedge i_clk_sys) disable iff (i_rst)
        strap_load |=> (sel_reg[0] == (opt_pat_reg ? 5'h00 : 5'h0F)))
        else $error("marker 1 default wrong");
    AST_DEF_MK2: assert property (
        @(posedge i_clk_sys) disable iff (i_rst)
        strap_load |=> (sel_reg[1] == 5'h01))
        else $error("marker 2 default wrong");
    AST_DEF_MK3: assert property (
        @(posedge i_clk_sys) disable iff (i_rst)
        strap_load |=> (sel_reg[2] == 5'h02))
        else $error("marker 3 default wrong");
    AST_DEF_PV: assert property (
        @(posedge i_clk_sys) disable iff (i_rst)
        strap_load |=> (sel_reg[3] == 5'h07))
        else $error("pulse video default wrong");
    AST_DEF_PS: assert property (
        @(posedge i_clk_sys) disable iff (i_rst)
        strap_load |=> (sel_reg[4] == 5'h06))
        else $error("pulse sync default wrong");
    AST_MK1_WRITE: assert property (
        @(posedge i_clk_sys) disable iff (i_rst)
        seq_mk1_write |=> seq_mk1_holds)
        else $error("marker 1 selector write lost");
    AST_READBACK: assert property (
        @(posedge i_clk_sys) disable iff (i_rst)
        (i_rd && (i_addr == 4'h3))
        |=> (o_rdata[4:0] == $past(sel_reg[3])))
        else $error("readback mismatch");
    AST_RDATA_IDLE: assert property (
        @(posedge i_clk_sys) disable iff (i_rst)
        !i_rd |=> (o_rdata == 32'h0000_0000))
        else $error("read data outside its cycle");
    AST_ROUTE: assert property (
        @(posedge i_clk_sys) disable iff (i_rst)
        ##1 (o_marker1 == $past(src_vec[sel_reg[0]])))
        else $error("marker 1 not routed");
    AST_ROUTE_PV: assert property (
        @(posedge i_clk_sys) disable iff (i_rst)
        ##1 (o_pulse_video == $past(src_vec[sel_reg[3]])))
        else $error("pulse video not routed");
endmodule

`default_nettype wire

// ### logic/ocsr_src_sync.sv
// Two-flop synchronisers packing all sources into one vector
`timescale 1ns/1ps
`default_nettype none

module ocsr_src_sync (
    input  wire logic        i_clk_sys,
    input  wire logic        i_rst,
    input  wire logic [31:0] i_raw,
    ocsr_src_if.producer     src
);
    logic [31:0] meta_reg;
    logic [31:0] sync_reg;

    always_ff @(posedge i_clk_sys)
    begin
        if (i_rst)
        begin
            meta_reg <= 32'h0000_0000;
            sync_reg <= 32'h0000_0000;
        end
        else
        begin
            meta_reg <= i_raw;
            sync_reg <= meta_reg;
        end
    end

    assign src.src_vec = sync_reg;
endmodule

`default_nettype wire

// ### sim/ocsr_far_end.sv
// Far-end instrument model sampling the retimed trigger outputs
`timescale 1ns/1ps
`default_nettype none

module ocsr_far_end (
    input  wire logic       i_clk_bbref,
    input  wire logic       i_sync_trig,
    input  wire logic [2:0] i_pattern_trig,
    output logic      [3:0] o_seen,
    output int              o_bad_edges
);
    initial o_bad_edges = 0;
    // Sample mid-cycle, away from the falling launch edge
    always @(posedge i_clk_bbref)
        o_seen <= {i_pattern_trig, i_sync_trig};
    // A change while the reference is high means a wrong launch edge
    always @(i_sync_trig or i_pattern_trig)
        if (i_clk_bbref === 1'b1)
            o_bad_edges = o_bad_edges + 1;
endmodule

`default_nettype wire

// ### sim/output_connector_signal_router_test.sv
// Self-checking bench for the output connector signal router
`timescale 1ns/1ps
`default_nettype none
`include "ocsr_params.svh"

module output_connector_signal_router_test;
    import ocsr_pkg::*;
    logic        clk_sys = 0, clk_bb = 0, rst = 1, opt_pat = 1, opt_g2 = 1;
    logic [3:0]  addr = 0;
    logic [31:0] wdata = 0, rdata, seed = 32'h0001_2B65;
    logic        wr = 0, rd = 0, frame = 0, pstat = 0, point = 0;
    logic [2:0]  ptrig = 0, ptrig_o;
    logic [5:0]  m1 = 0, m2 = 0;
    logic [1:0]  cyc = 0, gate = 0, settle = 0;
    logic        sync_o, mk1, mk2, mk3, pv, ps, rej_m;
    logic [3:0]  seen;
    int          bad_edges, bad_count = 0, checks = 0;
    int          sel_m[5];

    // Unrelated reference period so edges drift against the system clock
    always #20 clk_sys = ~clk_sys;
    always #13 clk_bb = ~clk_bb;

    ocsr_router ocsr_router_inst (.i_clk_sys(clk_sys), .i_rst(rst),
        .i_clk_bbref(clk_bb), .i_opt_pattern(opt_pat), .i_opt_gen2(opt_g2),
        .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd),
        .o_rdata(rdata), .i_frame_trig(frame), .i_pattern_trig(ptrig),
        .i_pattern_stat1_src(pstat), .i_point_switch(point),
        .i_gen1_marker(m1), .i_gen2_marker(m2), .i_cycle_start(cyc),
        .i_gate_follow(gate), .i_settling(settle), .o_sync_trig(sync_o),
        .o_pattern_trig(ptrig_o), .o_marker1(mk1), .o_marker2(mk2),
        .o_marker3(mk3), .o_pulse_video(pv), .o_pulse_sync(ps));

    ocsr_far_end ocsr_far_end_inst (.i_clk_bbref(clk_bb),
        .i_sync_trig(sync_o), .i_pattern_trig(ptrig_o), .o_seen(seen),
        .o_bad_edges(bad_edges));

    function automatic logic [31:0] rnd_next();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    // Source level by selector code, settled is the inverse of settling
    function automatic logic src_of(int c);
        logic [31:0] v;
        v = {7'h0, ~settle[1], gate[1], cyc[1], m2, point, 1'b0, pstat,
             ptrig, frame, ~settle[0], gate[0], cyc[0], m1};
        return v[c];
    endfunction

    function automatic bit ok(int k, int c);
        if (c > 24 || c == 14)
            return 0;
        if (!opt_pat && (k == 1 || k == 2 || !(c inside {6, 7, 8, 15,
            22, 23, 24})))
            return 0;
        if (!opt_g2 && c >= 16)
            return 0;
        return 1;
    endfunction

    task automatic tally_and_finish();
        if (bad_count == 0 && checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp)
        begin
            bad_count++;
            $display("mismatch at %0t: read %h want %h", $time, got, exp);
        end
    endtask

    task automatic chk_pin(input logic [3:0] got, input logic [3:0] exp);
        checks++;
        if (got !== exp)
        begin
            bad_count++;
            $display("mismatch at %0t: pins %b want %b", $time, got, exp);
        end
    endtask

    task automatic wr_sel(input int k, input logic [31:0] d);
        @(posedge clk_sys);
        wr <= 1;
        addr <= 4'(k);
        wdata <= d;
        @(posedge clk_sys);
        wr <= 0;
        rej_m = !(d[31:5] == 0 && ok(k, int'(d[4:0])));
        if (!rej_m)
            sel_m[k] = int'(d[4:0]);
    endtask

    task automatic rd_chk(input logic [3:0] a, input logic [31:0] exp);
        @(posedge clk_sys);
        rd <= 1;
        addr <= a;
        @(posedge clk_sys);
        rd <= 0;
        #1 chk_reg(rdata, exp);
    endtask

    task automatic route_chk(input int k);
        logic [31:0] r;
        logic [4:0]  outs;
        r = rnd_next();
        @(posedge clk_sys);
        {m1, m2, cyc, gate, settle, ptrig} <= r[20:0];
        {frame, pstat, point} <= r[23:21];
        // Three-cycle source latency, one cycle of margin
        repeat (4) @(posedge clk_sys);
        #1;
        outs = {ps, pv, mk3, mk2, mk1};
        chk_pin({3'h0, outs[k]}, {3'h0, src_of(sel_m[k])});
        chk_pin({ptrig_o, sync_o}, {ptrig, frame});
        chk_pin(seen, {ptrig, frame});
    endtask

    initial
    begin
        #(40 * 40000);
        bad_count++;
        tally_and_finish();
    end

    initial
    begin
        for (int ph = 0; ph < 4; ph++)
        begin
            @(posedge clk_sys);
            rst <= 1;
            opt_pat <= !ph[0];
            opt_g2 <= !ph[1];
            repeat (10) @(posedge clk_sys);
            rst <= 0;
            repeat (4) @(posedge clk_sys);
            sel_m = '{opt_pat ? OCSR_SRC_G1M1A : OCSR_SRC_POINT,
                OCSR_SRC_G1M2A, OCSR_SRC_G1M3A, OCSR_SRC_G1PVID,
                OCSR_SRC_G1PSY};
            rej_m = 0;
            for (int k = 0; k < 5; k++)
            begin
                rd_chk(4'(k), sel_m[k]);
                route_chk(k);
            end
            rd_chk(4'hA, 32'h0);
            for (int k = 0; k < 5; k++)
            begin
                for (int c = 0; c < 33; c++)
                begin
                    // Last pass sets random upper bits around code 0, 2, 4 or 6
                    wr_sel(k, c < 32 ? c : {rnd_next() | 32'h20} & ~32'h19);
                    rd_chk(4'(k), sel_m[k]);
                    rd_chk(`OCSR_OFS_STATUS, {29'h0, rej_m, opt_g2,
                        !opt_pat});
                    if (!rej_m)
                        route_chk(k);
                end
            end
        end
        chk_pin({3'h0, bad_edges != 0}, 4'h0);
        tally_and_finish();
    end
endmodule

`default_nettype wire
